// ### hdl/epac_host.sv
// Purpose: host controller for a byte-wide parallel EEPROM
// Assumes: software on Avalon-MM; one memory on the pins
// Notes:   page timing and end-of-write polling done here
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "epac_defines.svh"
module epac_host #(
   parameter int BYTE_LOAD_CYC = `EPAC_BYTE_LOAD_CYC,
   parameter int PROG_TMO_CYC  = 5 * `EPAC_WRITE_CYC,
   // Sequence pairs: entries 0-2 unlock, 3-8 disable (arbitrary values)
   parameter logic [`EPAC_ADDR_W-1:0] SEQ_ADDR [9] = '{
      13'h0A01, 13'h0502, 13'h0A03, 13'h0A04, 13'h0505,
      13'h0A06, 13'h0A07, 13'h0508, 13'h0A09},
   parameter logic [7:0] SEQ_DATA [9] = '{
      8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99}
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Avalon-MM slave
   input  wire logic [2:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // Memory pins
   output epac_pkg::epac_pins_t   pins,
   input  wire logic [7:0]        dq_in
);
   import epac_pkg::*;
   localparam int LW = $clog2(BYTE_LOAD_CYC + 1);
   localparam int TW = $clog2(PROG_TMO_CYC + 1);
   if (BYTE_LOAD_CYC < 16 || PROG_TMO_CYC < 16) begin : g_chk
      $error("timing counts too small for the cycle engine");
   end

   logic          wait_ff, nxt_wait;   // Registered waitrequest
   logic [31:0]   rdd_ff, nxt_rdd;     // Registered readdata
   logic [`EPAC_ADDR_W-1:0] addr_ff, nxt_addr; // Target address
   logic [7:0]    wdat_ff, nxt_wdat;   // Byte to write
   logic [7:0]    rbyte_ff, nxt_rbyte; // Last byte read
   logic          err_ff, nxt_err;     // Refused command, sticky
   logic          tmo_ff, nxt_tmo;     // Polling gave up, sticky
   logic          pend_ff, nxt_pend;   // Memory programming
   epac_op_st_t   st_ff, nxt_st;       // Command phase
   logic [2:0]    op_ff, nxt_op;       // Current command
   logic [3:0]    idx_ff, nxt_idx;     // Sequence entry
   logic [3:0]    end_ff, nxt_end;     // Last sequence entry
   logic [LW-1:0] ltmr_ff, nxt_ltmr;   // Byte-load window
   logic [6:0]    bcnt_ff, nxt_bcnt;   // Data bytes in page
   logic [`EPAC_ADDR_W-1:0] laddr_ff, nxt_laddr; // Last written addr
   logic [7:0]    ldat_ff, nxt_ldat;   // Last written byte
   logic          prev6_ff, nxt_prev6; // Previous status bit six
   logic          first_ff, nxt_first; // First poll read
   logic [TW-1:0] ptmr_ff, nxt_ptmr;   // Poll time used
   logic          go_ff, nxt_go;       // Cycle launch
   epac_req_t     creq_ff, nxt_creq;   // Cycle request
   logic          cdone, cwf;
   logic [7:0]    crd;
   logic          req, stall, acc, ctrl_wr, stat_wr, busy, page_open;
   logic          bad_page;

   epac_cycle u_cycle (
      .ref_clk (ref_clk),
      .reset   (reset),
      .go      (go_ff),
      .req     (creq_ff),
      .done    (cdone),
      .rdata   (crd),
      .we_fall (cwf),
      .pins    (pins),
      .dq_in   (dq_in)
   );

   assign busy      = (st_ff != S_IDLE) || go_ff;
   assign page_open = (ltmr_ff != '0);
   assign req       = avs_read || avs_write;
   // New commands wait on the bus instead of being lost
   assign stall     = avs_write && (avs_address == `EPAC_REG_CTRL) && busy;
   assign acc       = req && !wait_ff;
   assign ctrl_wr   = acc && avs_write && (avs_address == `EPAC_REG_CTRL);
   assign stat_wr   = acc && avs_write && (avs_address == `EPAC_REG_STATUS);
   // Page bits must match while the page is open
   assign bad_page  = page_open && (bcnt_ff != 7'h00) &&
      (addr_ff[`EPAC_ADDR_W-1:`EPAC_PAGE_LSB] !=
       laddr_ff[`EPAC_ADDR_W-1:`EPAC_PAGE_LSB]);

   // Bus slave: one wait cycle (more while a command stalls), then the transfer completes
   always_comb begin
      nxt_wait = 1'b1;
      nxt_rdd  = rdd_ff;
      nxt_addr = addr_ff;
      nxt_wdat = wdat_ff;
      if (req && wait_ff && !stall) begin
         nxt_wait = 1'b0;
         nxt_rdd  = 32'h0000_0000; // Unmapped reads give zero
         if (avs_read) begin
            unique case (avs_address)
               `EPAC_REG_ADDR:   nxt_rdd[`EPAC_ADDR_W-1:0] = addr_ff;
               `EPAC_REG_WDATA:  nxt_rdd[7:0] = wdat_ff;
               `EPAC_REG_STATUS: nxt_rdd[4:0] =
                  {tmo_ff, err_ff, pend_ff, page_open, busy};
               `EPAC_REG_RDATA:  nxt_rdd[7:0] = rbyte_ff;
               default:          nxt_rdd = 32'h0000_0000;
            endcase
         end
      end
      if (acc && avs_write && avs_address == `EPAC_REG_ADDR) begin
         nxt_addr = avs_writedata[`EPAC_ADDR_W-1:0];
      end
      if (acc && avs_write && avs_address == `EPAC_REG_WDATA) begin
         nxt_wdat = avs_writedata[7:0];
      end
   end

   // Command sequencer, page window and completion polling
   always_comb begin
      nxt_st    = st_ff;
      nxt_op    = op_ff;
      nxt_idx   = idx_ff;
      nxt_end   = end_ff;
      nxt_go    = 1'b0;
      nxt_creq  = creq_ff;
      nxt_rbyte = rbyte_ff;
      nxt_laddr = laddr_ff;
      nxt_ldat  = ldat_ff;
      nxt_prev6 = prev6_ff;
      nxt_first = first_ff;
      nxt_ptmr  = ptmr_ff;
      nxt_bcnt  = bcnt_ff;
      nxt_ltmr  = ltmr_ff;
      nxt_pend  = pend_ff;
      // Software clears come first so a same-cycle set wins
      nxt_err   = err_ff && !(stat_wr && avs_writedata[`EPAC_ST_ERR]);
      nxt_tmo   = tmo_ff && !(stat_wr && avs_writedata[`EPAC_ST_TMO]);
      unique case (st_ff)
         S_IDLE: begin
            if (ctrl_wr) begin
               nxt_op = avs_writedata[2:0];
               unique case (avs_writedata[2:0])
                  `EPAC_OP_READ: nxt_st = S_XF_GO;
                  `EPAC_OP_WRITE, `EPAC_OP_WRPROT: begin
                     // No load while busy, off page or over a page
                     if (pend_ff || bad_page ||
                         bcnt_ff == `EPAC_PAGE_BYTES) begin
                        nxt_err = 1'b1;
                     end else if (avs_writedata[2:0] == `EPAC_OP_WRPROT &&
                                  !page_open) begin
                        // Unlock opens each protected page
                        nxt_idx = `EPAC_UNL_FIRST;
                        nxt_end = `EPAC_UNL_LAST;
                        nxt_st  = S_SEQ_GO;
                     end else begin
                        nxt_st = S_XF_GO;
                     end
                  end
                  `EPAC_OP_POLL: begin
                     nxt_first = 1'b1;
                     nxt_ptmr  = '0;
                     nxt_st    = S_PL_GO;
                  end
                  `EPAC_OP_UNPROT: begin
                     if (pend_ff || page_open) begin
                        nxt_err = 1'b1;
                     end else begin
                        nxt_idx = `EPAC_DIS_FIRST;
                        nxt_end = `EPAC_DIS_LAST;
                        nxt_st  = S_SEQ_GO;
                     end
                  end
                  default: nxt_err = 1'b1;
               endcase
            end
         end
         S_SEQ_GO: begin
            // Sequence pairs come from parameters
            nxt_creq = '{wr: 1'b1, addr: SEQ_ADDR[idx_ff],
                         data: SEQ_DATA[idx_ff]};
            nxt_go   = 1'b1;
            nxt_st   = S_SEQ_WT;
         end
         S_SEQ_WT: begin
            if (cdone) begin
               if (idx_ff != end_ff) begin
                  nxt_idx = idx_ff + 4'h1;
                  nxt_st  = S_SEQ_GO;
               end else if (op_ff == `EPAC_OP_UNPROT) begin
                  nxt_st = S_IDLE;
               end else begin
                  nxt_st = S_XF_GO;
               end
            end
         end
         S_XF_GO: begin
            nxt_creq = '{wr: (op_ff != `EPAC_OP_READ), addr: addr_ff,
                         data: wdat_ff};
            nxt_go   = 1'b1;
            nxt_st   = S_XF_WT;
         end
         S_XF_WT: begin
            if (cdone) begin
               if (creq_ff.wr) begin
                  // Only data bytes count toward the page
                  nxt_laddr = creq_ff.addr;
                  nxt_ldat  = creq_ff.data;
                  nxt_bcnt  = bcnt_ff + 7'h01;
               end else begin
                  nxt_rbyte = crd;
               end
               nxt_st = S_IDLE;
            end
         end
         S_PL_GO: begin
            nxt_creq = '{wr: 1'b0, addr: laddr_ff, data: 8'h00};
            nxt_go   = 1'b1;
            nxt_st   = S_PL_WT;
         end
         S_PL_WT: begin
            nxt_ptmr = ptmr_ff + TW'(1);
            if (cdone) begin
               nxt_rbyte = crd;
               nxt_prev6 = crd[6];
               nxt_first = 1'b0;
               // Steady bit six and true bit seven mean done
               if (!first_ff && crd[6] == prev6_ff &&
                   crd[7] == ldat_ff[7]) begin
                  nxt_pend = 1'b0;
                  nxt_st   = S_IDLE;
               end else if (ptmr_ff >= TW'(PROG_TMO_CYC)) begin
                  nxt_tmo  = 1'b1;
                  nxt_pend = 1'b0; // Give up, else no write or unprotect runs again
                  nxt_st   = S_IDLE;
               end else begin
                  nxt_st = S_PL_GO;
               end
            end
         end
         default: nxt_st = S_IDLE;
      endcase
      // Each falling strobe reopens the byte-load window
      if (cwf) begin
         nxt_ltmr = LW'(BYTE_LOAD_CYC);
      end else if (page_open) begin
         nxt_ltmr = ltmr_ff - LW'(1);
         if (ltmr_ff == LW'(1)) begin
            // Window lapses: memory starts programming
            nxt_pend = 1'b1;
            nxt_bcnt = 7'h00;
         end
      end
   end

   // Register all state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wait_ff  <= 1'b1;
         rdd_ff   <= 32'h0000_0000;
         addr_ff  <= '0;
         wdat_ff  <= 8'h00;
         rbyte_ff <= 8'h00;
         err_ff   <= 1'b0;
         tmo_ff   <= 1'b0;
         pend_ff  <= 1'b0;
         st_ff    <= S_IDLE;
         op_ff    <= 3'h0;
         idx_ff   <= 4'h0;
         end_ff   <= 4'h0;
         ltmr_ff  <= '0;
         bcnt_ff  <= 7'h00;
         laddr_ff <= '0;
         ldat_ff  <= 8'h00;
         prev6_ff <= 1'b0;
         first_ff <= 1'b0;
         ptmr_ff  <= '0;
         go_ff    <= 1'b0;
         creq_ff  <= '0;
      end else begin
         wait_ff  <= nxt_wait;
         rdd_ff   <= nxt_rdd;
         addr_ff  <= nxt_addr;
         wdat_ff  <= nxt_wdat;
         rbyte_ff <= nxt_rbyte;
         err_ff   <= nxt_err;
         tmo_ff   <= nxt_tmo;
         pend_ff  <= nxt_pend;
         st_ff    <= nxt_st;
         op_ff    <= nxt_op;
         idx_ff   <= nxt_idx;
         end_ff   <= nxt_end;
         ltmr_ff  <= nxt_ltmr;
         bcnt_ff  <= nxt_bcnt;
         laddr_ff <= nxt_laddr;
         ldat_ff  <= nxt_ldat;
         prev6_ff <= nxt_prev6;
         first_ff <= nxt_first;
         ptmr_ff  <= nxt_ptmr;
         go_ff    <= nxt_go;
         creq_ff  <= nxt_creq;
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata    = rdd_ff;

   sequence unlock_start;
      st_ff == S_SEQ_GO && idx_ff == `EPAC_UNL_FIRST;
   endsequence
   a_page_window: assert property (@(posedge ref_clk) disable iff (reset)
      cwf |=> page_open [*8])
      else $error("page window not opened by strobe");
   a_page_close: assert property (@(posedge ref_clk) disable iff (reset)
      (ltmr_ff == LW'(1) && !cwf) |=> (pend_ff && !page_open))
      else $error("lapsed window did not mark programming");
   a_bad_page: assert property (@(posedge ref_clk) disable iff (reset)
      (ctrl_wr && st_ff == S_IDLE && bad_page &&
       avs_writedata[2:0] == `EPAC_OP_WRITE) |=> (err_ff && st_ff == S_IDLE))
      else $error("off-page write not refused");
   a_unlock_first: assert property (@(posedge ref_clk) disable iff (reset)
      unlock_start |=> (go_ff && creq_ff.wr && creq_ff.addr == SEQ_ADDR[0]))
      else $error("unlock does not start at first pair");
   a_busy_refuse: assert property (@(posedge ref_clk) disable iff (reset)
      (ctrl_wr && pend_ff && avs_writedata[2:0] == `EPAC_OP_WRITE)
      |=> (err_ff && !go_ff))
      else $error("write accepted while programming");
   a_stall_hold: assert property (@(posedge ref_clk) disable iff (reset)
      stall |=> avs_waitrequest)
      else $error("command accepted while busy");
   a_poll_done: assert property (@(posedge ref_clk) disable iff (reset)
      (st_ff == S_PL_WT && cdone && !first_ff && crd[6] == prev6_ff &&
       crd[7] == ldat_ff[7]) |=> (!pend_ff && st_ff == S_IDLE))
      else $error("completion not recognised");
endmodule
`default_nettype wire

// ### hdl/epac_defines.svh
// Purpose: constants of the parallel EEPROM access controller
// Assumes: ref_clk at 20 MHz; 13 address lines, 8 data lines
// Notes:   register map is word indexed on the Avalon-MM slave
`ifndef EPAC_DEFINES_SVH
`define EPAC_DEFINES_SVH
`define EPAC_ADDR_W        13
`define EPAC_PAGE_LSB      6
`define EPAC_PAGE_BYTES    7'h40
`define EPAC_CLK_HZ        20000000
`define EPAC_BYTE_LOAD_US  100
`define EPAC_BYTE_LOAD_CYC ((`EPAC_BYTE_LOAD_US*`EPAC_CLK_HZ)/1000000)
`define EPAC_WRITE_MS      2
`define EPAC_WRITE_CYC     ((`EPAC_WRITE_MS*`EPAC_CLK_HZ)/1000)
`define EPAC_WR_CYC        3'h4
`define EPAC_RD_CYC        3'h5
`define EPAC_REG_CTRL      3'h0
`define EPAC_REG_ADDR      3'h1
`define EPAC_REG_WDATA     3'h2
`define EPAC_REG_STATUS    3'h3
`define EPAC_REG_RDATA     3'h4
`define EPAC_OP_READ       3'h1
`define EPAC_OP_WRITE      3'h2
`define EPAC_OP_WRPROT     3'h3
`define EPAC_OP_POLL       3'h4
`define EPAC_OP_UNPROT     3'h5
`define EPAC_ST_BUSY       0
`define EPAC_ST_PAGE       1
`define EPAC_ST_PEND       2
`define EPAC_ST_ERR        3
`define EPAC_ST_TMO        4
`define EPAC_UNL_FIRST     4'h0
`define EPAC_UNL_LAST      4'h2
`define EPAC_DIS_FIRST     4'h3
`define EPAC_DIS_LAST      4'h8
`endif

// ### hdl/epac_pkg.sv
// Purpose: shared types of the EEPROM access controller
// Assumes: epac_defines.svh holds every number
// Notes:   pins travel as one packed struct
`include "epac_defines.svh"
package epac_pkg;
   // Pin group towards the memory
   typedef struct packed {
      logic                    ce_n;
      logic                    oe_n;
      logic                    we_n;
      logic [`EPAC_ADDR_W-1:0] addr;
      logic [7:0]              dq_out;
      logic                    dq_oe;
   } epac_pins_t;
   // One bus cycle request
   typedef struct packed {
      logic                    wr;
      logic [`EPAC_ADDR_W-1:0] addr;
      logic [7:0]              data;
   } epac_req_t;
   typedef enum logic [2:0] {
      C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_GAP
   } epac_cyc_st_t;
   typedef enum logic [2:0] {
      S_IDLE, S_SEQ_GO, S_SEQ_WT, S_XF_GO, S_XF_WT, S_PL_GO, S_PL_WT
   } epac_op_st_t;
endpackage

// ### hdl/epac_cycle.sv
// Purpose: one read or write cycle on the memory pins
// Assumes: go only while idle; dq_in is asynchronous
// Notes:   write is strobe controlled, chip select brackets it
`timescale 1ns/1ps
`default_nettype none
`include "epac_defines.svh"
module epac_cycle (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Request side
   input  wire logic              go,
   input  wire epac_pkg::epac_req_t req,
   output logic                   done,
   output logic [7:0]             rdata,
   output logic                   we_fall,
   // Memory pins
   output epac_pkg::epac_pins_t   pins,
   input  wire logic [7:0]        dq_in
);
   import epac_pkg::*;
   epac_cyc_st_t st_ff, nxt_st;      // Cycle phase
   logic [2:0]   cnt_ff, nxt_cnt;    // Strobe width counter
   epac_req_t    req_ff, nxt_req;    // Held request
   epac_pins_t   pins_ff, nxt_pins;  // Pin drivers
   logic         done_ff, nxt_done;  // End of cycle pulse
   logic         wf_ff, nxt_wf;      // Falling write strobe pulse
   logic [7:0]   rd_ff, nxt_rd;      // Captured read byte
   logic [7:0]   s1_ff, s2_ff;       // Data input synchroniser

   // Next phase and pin levels
   always_comb begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_req  = req_ff;
      nxt_pins = pins_ff;
      nxt_done = 1'b0;
      nxt_wf   = 1'b0;
      nxt_rd   = rd_ff;
      unique case (st_ff)
         C_IDLE: begin
            if (go) begin
               // Select first with both strobes high
               nxt_req         = req;
               nxt_pins.ce_n   = 1'b0;
               nxt_pins.oe_n   = 1'b1;
               nxt_pins.we_n   = 1'b1;
               nxt_pins.addr   = req.addr;
               nxt_pins.dq_out = req.data;
               nxt_pins.dq_oe  = req.wr;
               nxt_st          = C_SETUP;
            end
         end
         C_SETUP: begin
            if (req_ff.wr) begin
               // Strobe falls last, so it latches the address
               nxt_pins.we_n = 1'b0;
               nxt_wf        = 1'b1;
               nxt_cnt       = `EPAC_WR_CYC - 3'h1;
            end else begin
               nxt_pins.oe_n = 1'b0;
               nxt_cnt       = `EPAC_RD_CYC - 3'h1;
            end
            nxt_st = C_STROBE;
         end
         C_STROBE: begin
            if (cnt_ff == 3'h0) begin
               // Strobe rises before select, so it latches data
               nxt_pins.we_n = 1'b1;
               nxt_pins.oe_n = 1'b1;
               if (!req_ff.wr) begin
                  nxt_rd = s2_ff;
               end
               nxt_st = C_HOLD;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         C_HOLD: begin
            // Data held two cycles past the strobe edge
            nxt_pins.ce_n = 1'b1;
            nxt_st        = C_GAP;
         end
         C_GAP: begin
            nxt_pins.dq_oe = 1'b0;
            nxt_done       = 1'b1;
            nxt_st         = C_IDLE;
         end
      endcase
   end

   // Register phase, pins and the two-stage input synchroniser
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_ff   <= C_IDLE;
         cnt_ff  <= 3'h0;
         req_ff  <= '0;
         pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
         done_ff <= 1'b0;
         wf_ff   <= 1'b0;
         rd_ff   <= 8'h00;
         s1_ff   <= 8'h00;
         s2_ff   <= 8'h00;
      end else begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         req_ff  <= nxt_req;
         pins_ff <= nxt_pins;
         done_ff <= nxt_done;
         wf_ff   <= nxt_wf;
         rd_ff   <= nxt_rd;
         s1_ff   <= dq_in;
         s2_ff   <= s1_ff;
      end
   end

   assign pins    = pins_ff;
   assign done    = done_ff;
   assign rdata   = rd_ff;
   assign we_fall = wf_ff;

   sequence we_pulse;
      !pins_ff.we_n [*4] ##1 pins_ff.we_n;
   endsequence
   sequence oe_pulse;
      !pins_ff.oe_n [*5] ##1 pins_ff.oe_n;
   endsequence
   a_strobe_excl: assert property (@(posedge ref_clk) disable iff (reset)
      !(!pins_ff.oe_n && !pins_ff.we_n))
      else $error("both strobes low");
   a_drive_released: assert property (@(posedge ref_clk) disable iff (reset)
      pins_ff.dq_oe |-> pins_ff.oe_n)
      else $error("data driven while output enable low");
   a_strobe_select: assert property (@(posedge ref_clk) disable iff (reset)
      (!pins_ff.oe_n || !pins_ff.we_n) |-> !pins_ff.ce_n)
      else $error("strobe without chip select");
   a_we_width: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(pins_ff.we_n) |-> we_pulse ##1 pins_ff.ce_n)
      else $error("write strobe width wrong");
   a_oe_width: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(pins_ff.oe_n) |-> oe_pulse)
      else $error("read strobe width wrong");
endmodule
`default_nettype wire

// ### verification/epac_mem_model.sv
// Purpose: behavioural byte-wide EEPROM standing on the pins
// Assumes: strobe-timed writes from the controller
// Notes:   any read ends an unlocked page, to stay brief
`timescale 1ns/1ps
`default_nettype none
module epac_mem_model #(
   parameter int          PROG_NS = 5000,
   parameter logic [12:0] SA [9]  = '{default: 13'h0000},
   parameter logic [7:0]  SD [9]  = '{default: 8'h00}
) (
   // Pins from the controller
   input  wire epac_pkg::epac_pins_t pins,
   // Data lines back
   output logic [7:0]                dq
);
   logic [7:0]  mem [8192];   // Array, unknown until written
   logic [12:0] la;           // Latched address
   logic [7:0]  lb   = 8'h00; // Last byte programmed
   logic [7:0]  hold = 8'h00; // Last byte driven
   logic        tog  = 1'b0;  // Alternating status bit
   logic        prot = 1'b0;  // Off as shipped
   int          sq   = 0;     // Sequence step
   time         t_end = 0;    // End of programming
   // Address at the later falling edge, only with enable high
   always @(negedge pins.we_n)
      if (!pins.ce_n && pins.oe_n) la = pins.addr;
   // Data at the first rising edge
   always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n) begin
      if (sq < 9 && la == SA[sq] && pins.dq_out == SD[sq]) begin
         sq = sq + 1;
      end else if (sq == 0 && la == SA[3] && pins.dq_out == SD[3]) begin
         sq = 4; // Disable runs on its own six pairs
      end else if (!prot || sq == 3) begin
         mem[la] = pins.dq_out;
         lb = pins.dq_out;
         t_end = $time + PROG_NS;
         if (sq == 3) prot = 1'b1;
         else sq = 0;
      end else sq = 0;
      if (sq == 9) begin
         prot = 1'b0;
         sq = 0;
      end
   end
   // Each read while programming flips the status bit
   always @(negedge pins.oe_n) if (!pins.ce_n) begin
      if ($time < t_end) tog = ~tog;
      if (sq == 3) sq = 0;
      #10 hold = dq;
   end
   // Released lines show an inverse, never the last value
   always @* begin
      if (!pins.ce_n && !pins.oe_n && $time < t_end)
         dq = {~lb[7], tog, lb[5:0]};
      else if (!pins.ce_n && !pins.oe_n) dq = mem[pins.addr];
      else dq = ~hold;
   end
endmodule
`default_nettype wire

// ### verification/epac_host_test.sv
// Purpose: self-checking bench for the EEPROM access controller
// Assumes: memory model on the pins, short page and poll limits
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module epac_host_test;
   import epac_pkg::*;
   // Sequence pairs, arbitrary values
   localparam logic [12:0] SA [9] = '{13'h0A01, 13'h0502, 13'h0A03,
      13'h0A04, 13'h0505, 13'h0A06, 13'h0A07, 13'h0508, 13'h0A09};
   localparam logic [7:0] SD [9] = '{8'h11, 8'h22, 8'h33, 8'h44,
      8'h55, 8'h66, 8'h77, 8'h88, 8'h99};
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   epac_pins_t  pins;
   logic [7:0]  dq;
   logic [31:0] q;               // Last bus read
   int          num_errors = 0;
   int          checks_done = 0;
   epac_host #(.BYTE_LOAD_CYC(40), .PROG_TMO_CYC(200), .SEQ_ADDR(SA),
      .SEQ_DATA(SD)) dut_u (.ref_clk(ref_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pins(pins), .dq_in(dq));
   epac_mem_model #(.SA(SA), .SD(SD)) mem_u (.pins(pins), .dq(dq));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic cmd(input logic [2:0] op, input logic [12:0] a,
                      input logic [7:0] d);
      bus(1'b1, 3'h1, {19'h0, a});
      bus(1'b1, 3'h2, {24'h0, d});
      bus(1'b1, 3'h0, {29'h0, op});
      do bus(1'b0, 3'h3, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic t_byte();
      time t0;
      chk({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 32'hE);
      bus(1'b0, 3'h5, 32'h0);
      chk(q, 32'h0);
      cmd(3'h2, 13'h0123, 8'hA5);
      repeat (50) @(posedge ref_clk);
      bus(1'b0, 3'h3, 32'h0);
      chk(q[2:1], 32'h2);
      cmd(3'h4, 13'h0123, 8'hA5);
      bus(1'b0, 3'h3, 32'h0);
      chk(q, 32'h0);
      cmd(3'h1, 13'h0123, 8'h00);
      bus(1'b0, 3'h4, 32'h0);
      chk(q, 32'hA5);
      // A second command while busy must wait on the bus, not be lost
      bus(1'b1, 3'h0, 32'h1);
      t0 = $time;
      bus(1'b1, 3'h0, 32'h1);
      chk(32'(($time - t0) > 300), 32'h1);
      do bus(1'b0, 3'h3, 32'h0); while (q[0] !== 1'b0);
      bus(1'b0, 3'h4, 32'h0);
      chk(q, 32'hA5);
   endtask
   task automatic t_page();
      cmd(3'h2, 13'h0140, 8'h11);
      cmd(3'h2, 13'h017F, 8'h22);
      cmd(3'h4, 13'h017F, 8'h22);
      chk({mem_u.mem[13'h0140], mem_u.mem[13'h017F]}, 32'h1122);
      cmd(3'h2, 13'h0200, 8'h33);
      cmd(3'h2, 13'h0240, 8'h44);
      bus(1'b0, 3'h3, 32'h0);
      chk(q[3], 32'h1);
      chk(mem_u.mem[13'h0240], {24'h0, 8'hXX});
      bus(1'b1, 3'h3, 32'h8);
      cmd(3'h4, 13'h0200, 8'h33);
      bus(1'b0, 3'h3, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_prot();
      cmd(3'h3, 13'h0050, 8'h3C);
      cmd(3'h4, 13'h0050, 8'h3C);
      chk({mem_u.prot, mem_u.mem[13'h0050]}, 32'h13C);
      chk(mem_u.mem[SA[0]], {24'h0, 8'hXX});
      cmd(3'h2, 13'h0050, 8'hC3);
      cmd(3'h4, 13'h0050, 8'hC3);
      bus(1'b0, 3'h3, 32'h0);
      chk({q[4], mem_u.mem[13'h0050]}, 32'h13C);
      bus(1'b1, 3'h3, 32'h10);
      cmd(3'h5, 13'h0000, 8'h00);
      cmd(3'h2, 13'h0050, 8'hC3);
      cmd(3'h4, 13'h0050, 8'hC3);
      chk({mem_u.prot, mem_u.mem[13'h0050]}, 32'hC3);
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog: the whole run needs well under a millisecond
   initial begin
      #2ms;
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      t_byte();
      t_page();
      t_prot();
      finish_test();
   end
endmodule
`default_nettype wire
